// >>> pkg/pdid_pkg.sv
// constants and types for the power-down, id and otp command block
package pdid_pkg;
    // ====================================================
    // timing
    localparam int CLK_MHZ     = 100;
    localparam int PD_ENTRY_NS = 10000;
    localparam int PD_REL_NS   = 10000;
    // entry is a least wait: round up; release is a longest time: round down
    localparam int PD_ENTRY_CYC = (PD_ENTRY_NS * CLK_MHZ + 999) / 1000;
    localparam int PD_REL_CYC   = (PD_REL_NS * CLK_MHZ) / 1000;
    localparam logic [15:0] PD_ENTRY_LOAD = 16'(PD_ENTRY_CYC - 1);
    localparam logic [15:0] PD_REL_LOAD   = 16'(PD_REL_CYC - 1);

    // ====================================================
    // framing
    localparam logic [5:0] SPI_OP_CLKS     = 6'h08;
    localparam logic [5:0] QPI_OP_CLKS     = 6'h02;
    localparam logic [5:0] MAKER_HDR_CLKS  = 6'h20;
    localparam logic [5:0] HCNT_MAX        = 6'h3f;
    localparam logic [7:0] MAKER_ID_OP     = 8'h90;
    localparam logic [7:0] MAKER_SWAP_ADDR = 8'h01;
    localparam logic [3:0] SIG_LAST        = 4'h7;
    localparam logic [3:0] MAKER_LAST      = 4'hf;
    localparam logic [3:0] QID_LAST        = 4'h5;
    localparam logic [3:0] QBYTE_LAST      = 4'h1;
    localparam logic [3:0] SPI_OE          = 4'h2;
    localparam logic [3:0] QPI_OE          = 4'hf;

    // ====================================================
    // types
    typedef enum logic [1:0] {ST_STANDBY, ST_ENTER, ST_DOWN, ST_RELEASE} pwr_state_t;
    typedef enum logic [2:0] {RD_NONE, RD_SIG, RD_MAKER, RD_QID, RD_FLAGS} rd_kind_t;

    typedef struct packed {
        logic protect_method_select;
        logic e_fail;
        logic p_fail;
        logic rsvd;
        logic erase_suspended_flag;
        logic program_suspended_flag;
        logic otp_lockdown_bit;
        logic factory;
    } sec_flags_t;

    localparam sec_flags_t FLAGS_RESET = 8'h00;

    // opcode report, link to system
    typedef struct packed {
        logic [7:0] code;
        logic       quad;
        logic       tog;
        logic       over;
    } cmd_report_t;

    // core state, system to link
    typedef struct packed {
        logic       pd;
        logic       busy;
        sec_flags_t flags;
    } core_view_t;
endpackage

// >>> design/pdid_cmd.sv
// power-down, id read and otp mode command handling, both clock domains
`timescale 1ns/1ns
`default_nettype none
module pdid_cmd #(
    parameter logic [7:0] OP_PD_ENTER   = 8'hb9,
    parameter logic [7:0] OP_RELEASE    = 8'hab,
    parameter logic [7:0] OP_QUAD_ID    = 8'haf,
    parameter logic [7:0] OP_OTP_ENTER  = 8'hb1,
    parameter logic [7:0] OP_OTP_EXIT   = 8'hc1,
    parameter logic [7:0] OP_FLAGS_READ = 8'h2b,
    // identity values are arbitrary
    parameter logic [7:0] ID_MAKER      = 8'h5a,
    parameter logic [7:0] ID_TYPE       = 8'h3c,
    parameter logic [7:0] ID_PART       = 8'h17
) (
    // system clock
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    // serial link
    input  wire logic                 sclk_i,
    input  wire logic                 cs_n_i,
    input  wire logic [3:0]           sio_i,
    output var  logic [3:0]           sio_o,
    output var  logic [3:0]           sio_oe_o,
    input  wire logic                 quad_mode_i,
    // core events
    input  wire logic                 busy_i,
    input  wire logic                 sw_reset_i,
    input  wire logic                 erase_suspend_i,
    input  wire logic                 erase_resume_i,
    input  wire logic                 prog_suspend_i,
    input  wire logic                 prog_resume_i,
    input  wire logic                 erase_fail_i,
    input  wire logic                 prog_fail_i,
    input  wire logic                 fail_clear_i,
    input  wire logic                 protect_method_select_set_i,
    input  wire logic                 lockdown_req_i,
    input  wire logic                 nv_protect_method_select_i,
    input  wire logic                 nv_otp_lockdown_bit_i,
    input  wire logic                 factory_lock_i,
    // status
    output var  logic                 power_down_o,
    output var  logic                 otp_mode_o,
    output var  logic                 reg_write_block_o,
    output var  logic                 otp_read_only_o,
    output var  pdid_pkg::sec_flags_t security_flags_o
);
    import pdid_pkg::*;

    // ====================================================
    // declarations
    cmd_report_t rpt, next_rpt;
    core_view_t  view_s1, view_s2;
    logic [2:0]  sync1, sync2;
    logic        cs_d, busy_q, tog_seen, next_seen;
    logic        cs_rise, new_code, exact, release_cmd;
    pwr_state_t  state, next_state;
    logic [15:0] timer, next_timer;
    logic        next_otp;
    sec_flags_t  next_flags;
    logic [5:0]  hcnt, next_hcnt, op_len, hdr;
    logic [7:0]  sh, next_sh, out_byte;
    logic        fq, fq_now, next_fq, op_done;
    rd_kind_t    kind, next_kind;
    logic        active, next_active, swap, next_swap;
    logic [3:0]  dcnt, next_dcnt, last, next_o, next_oe;

    // ====================================================
    // crossings
    // first stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            sync1  <= 3'h7;
            sync2  <= 3'h7;
            cs_d   <= 1'b1;
            busy_q <= 1'b0;
        end
        else
        begin
            sync1  <= {cs_n_i, rpt.tog, rpt.over};
            sync2  <= sync1;
            cs_d   <= sync2[2];
            busy_q <= busy_i;
        end
    end

    // flags are independent levels, so per-bit sync is safe
    always_ff @(posedge sclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            view_s1 <= '0;
            view_s2 <= '0;
        end
        else
        begin
            view_s1 <= {power_down_o, busy_q, security_flags_o};
            view_s2 <= view_s1;
        end
    end

    // ====================================================
    // power state and flags
    // rpt.code and rpt.quad are stable here: sclk stops before cs rises
    assign cs_rise     = sync2[2] & ~cs_d;
    assign new_code    = cs_rise & (sync2[1] != tog_seen);
    assign exact       = new_code & ~sync2[0];
    assign release_cmd = new_code & (rpt.code == OP_RELEASE)
                       & ~rpt.quad & ~busy_q;

    always_comb
    begin
        next_state = state;
        next_timer = timer;
        next_otp   = otp_mode_o;
        next_flags = security_flags_o;
        next_seen  = cs_rise ? sync2[1] : tog_seen;
        // anything but release is dropped outside standby
        case (state)
            ST_STANDBY:
            begin
                if (exact && rpt.code == OP_PD_ENTER)
                begin
                    next_state = ST_ENTER;
                    next_timer = PD_ENTRY_LOAD;
                end
                if (exact && rpt.code == OP_OTP_ENTER)
                    next_otp = 1'b1;
                if (exact && rpt.code == OP_OTP_EXIT)
                    next_otp = 1'b0;
            end
            ST_ENTER:
            begin
                if (release_cmd)
                    next_state = ST_STANDBY;
                else if (timer == 16'h0000)
                    next_state = ST_DOWN;
                else
                    next_timer = timer - 16'h0001;
            end
            ST_DOWN:
            begin
                if (release_cmd)
                begin
                    next_state = ST_RELEASE;
                    next_timer = PD_REL_LOAD;
                end
            end
            ST_RELEASE:
            begin
                if (timer == 16'h0000)
                    next_state = ST_STANDBY;
                else
                    next_timer = timer - 16'h0001;
            end
            default:
                next_state = ST_STANDBY;
        endcase
        // otp bits only ever set; set wins over every clear
        next_flags.protect_method_select   = security_flags_o.protect_method_select | protect_method_select_set_i | nv_protect_method_select_i;
        next_flags.otp_lockdown_bit    = security_flags_o.otp_lockdown_bit | nv_otp_lockdown_bit_i
                           | (lockdown_req_i & ~otp_mode_o);
        next_flags.factory = factory_lock_i;
        next_flags.rsvd    = 1'b0;
        next_flags.e_fail  = erase_fail_i
                           | (security_flags_o.e_fail & ~fail_clear_i & ~sw_reset_i);
        next_flags.p_fail  = prog_fail_i
                           | (security_flags_o.p_fail & ~fail_clear_i & ~sw_reset_i);
        next_flags.erase_suspended_flag     = erase_suspend_i
                           | (security_flags_o.erase_suspended_flag & ~erase_resume_i & ~sw_reset_i);
        next_flags.program_suspended_flag     = prog_suspend_i
                           | (security_flags_o.program_suspended_flag & ~prog_resume_i & ~sw_reset_i);
        if (sw_reset_i)
        begin
            next_state = ST_STANDBY;
            next_otp   = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state             <= ST_STANDBY;
            timer             <= 16'h0000;
            tog_seen          <= 1'b0;
            otp_mode_o        <= 1'b0;
            security_flags_o  <= FLAGS_RESET;
            power_down_o      <= 1'b0;
            reg_write_block_o <= 1'b0;
            otp_read_only_o   <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            timer             <= next_timer;
            tog_seen          <= next_seen;
            otp_mode_o        <= next_otp;
            security_flags_o  <= next_flags;
            power_down_o      <= (next_state == ST_DOWN) || (next_state == ST_RELEASE);
            reg_write_block_o <= (next_state != ST_STANDBY) || next_otp;
            otp_read_only_o   <= next_otp & next_flags.otp_lockdown_bit;
        end
    end

    // ====================================================
    // link: opcode capture and read sequencing
    always_comb
    begin
        fq_now      = (hcnt == 6'h00) ? quad_mode_i : fq;
        op_len      = fq_now ? QPI_OP_CLKS : SPI_OP_CLKS;
        next_fq     = fq_now;
        next_hcnt   = (hcnt == HCNT_MAX) ? hcnt : hcnt + 6'h01;
        // upper lines are don't care in serial mode
        next_sh     = fq_now ? {sh[3:0], sio_i} : {sh[6:0], sio_i[0]};
        op_done     = (next_hcnt == op_len);
        next_rpt    = rpt;
        next_kind   = kind;
        next_active = active;
        next_dcnt   = dcnt;
        next_swap   = swap;
        if (op_done)
        begin
            next_rpt.code = next_sh;
            next_rpt.quad = fq_now;
            next_rpt.tog  = ~rpt.tog;
            next_rpt.over = 1'b0;
            if (next_sh == OP_RELEASE && !fq_now && !view_s2.busy)
                next_kind = RD_SIG;
            else if (!view_s2.pd)
            begin
                if (next_sh == MAKER_ID_OP && !fq_now)
                    next_kind = RD_MAKER;
                else if (next_sh == OP_QUAD_ID && fq_now)
                    next_kind = RD_QID;
                else if (next_sh == OP_FLAGS_READ)
                    next_kind = RD_FLAGS;
            end
        end
        else
            next_rpt.over = 1'b1;
        hdr = (next_kind == RD_MAKER) ? MAKER_HDR_CLKS : op_len;
        case (kind)
            RD_SIG:   last = SIG_LAST;
            RD_MAKER: last = MAKER_LAST;
            RD_QID:   last = QID_LAST;
            RD_FLAGS: last = fq ? QBYTE_LAST : SIG_LAST;
            default:  last = SIG_LAST;
        endcase
        if (active)
            next_dcnt = (dcnt == last) ? 4'h0 : dcnt + 4'h1;
        else if (next_kind != RD_NONE && next_hcnt == hdr)
        begin
            next_active = 1'b1;
            next_dcnt   = 4'h0;
            next_swap   = (next_kind == RD_MAKER) && (next_sh == MAKER_SWAP_ADDR);
        end
    end

    // frame state dies with cs; the report survives it for the system side
    always_ff @(posedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            hcnt   <= 6'h00;
            sh     <= 8'h00;
            fq     <= 1'b0;
            kind   <= RD_NONE;
            active <= 1'b0;
            dcnt   <= 4'h0;
            swap   <= 1'b0;
        end
        else
        begin
            hcnt   <= next_hcnt;
            sh     <= next_sh;
            fq     <= next_fq;
            kind   <= next_kind;
            active <= next_active;
            dcnt   <= next_dcnt;
            swap   <= next_swap;
        end
    end

    always_ff @(posedge sclk_i or posedge reset_i)
    begin
        if (reset_i)
            rpt <= '0;
        else
            rpt <= next_rpt;
    end

    // ====================================================
    // link: output on falling edges, msb first
    always_comb
    begin
        next_o  = 4'h0;
        next_oe = 4'h0;
        case (kind)
            RD_SIG:   out_byte = ID_PART;
            RD_MAKER: out_byte = (dcnt[3] ^ swap) ? ID_PART : ID_MAKER;
            RD_QID:   out_byte = (dcnt[3:1] == 3'h0) ? ID_MAKER
                               : (dcnt[3:1] == 3'h1) ? ID_TYPE : ID_PART;
            RD_FLAGS: out_byte = view_s2.flags;
            default:  out_byte = 8'h00;
        endcase
        if (active)
        begin
            if (fq)
            begin
                next_oe = QPI_OE;
                next_o  = dcnt[0] ? out_byte[3:0] : out_byte[7:4];
            end
            else
            begin
                next_oe = SPI_OE;
                next_o  = {2'b00, out_byte[~dcnt[2:0]], 1'b0};
            end
        end
    end

    always_ff @(negedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            sio_o    <= 4'h0;
            sio_oe_o <= 4'h0;
        end
        else
        begin
            sio_o    <= next_o;
            sio_oe_o <= next_oe;
        end
    end

    // ====================================================
    // checks
    chk_entry_delay: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_STANDBY && next_state == ST_ENTER |=> timer == PD_ENTRY_LOAD
        && !power_down_o) else $error("entry delay not loaded");
    chk_entry_end: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_ENTER && timer == 16'h0000 && !release_cmd && !sw_reset_i
        |=> state == ST_DOWN && power_down_o) else $error("no power-down entry");
    chk_pd_blocks: assert property (@(posedge clk_i) disable iff (reset_i)
        power_down_o |-> reg_write_block_o) else $error("writes open in power-down");
    chk_release_wait: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_DOWN && release_cmd && !sw_reset_i |=> state == ST_RELEASE
        && timer == PD_REL_LOAD) else $error("release delay wrong");
    chk_no_inexact: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_STANDBY && !exact && !sw_reset_i |=> state == ST_STANDBY)
        else $error("inexact frame acted on");
    chk_otp_exit: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_STANDBY && exact && rpt.code == OP_OTP_EXIT |=> !otp_mode_o)
        else $error("otp exit ignored");
    chk_otp_enter: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_STANDBY && exact && rpt.code == OP_OTP_ENTER && !sw_reset_i
        |=> otp_mode_o && reg_write_block_o) else $error("otp entry ignored");
    chk_sw_reset: assert property (@(posedge clk_i) disable iff (reset_i)
        sw_reset_i |=> state == ST_STANDBY && !otp_mode_o ##1 !power_down_o)
        else $error("reset left power-down");
    chk_otp_lockdown_bit_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
        security_flags_o.otp_lockdown_bit |=> security_flags_o.otp_lockdown_bit) else $error("lock-down lost");
    chk_esb_set: assert property (@(posedge clk_i) disable iff (reset_i)
        erase_suspend_i |=> security_flags_o.erase_suspended_flag) else $error("suspend flag not set");
    chk_fail_set: assert property (@(posedge clk_i) disable iff (reset_i)
        erase_fail_i && prog_fail_i |=> security_flags_o.e_fail && security_flags_o.p_fail
        && !security_flags_o.rsvd) else $error("fail flags wrong");
    chk_sig_serial: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        kind == RD_SIG || kind == RD_MAKER |-> !fq) else $error("serial-only read in quad");
    chk_pd_reads: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        $rose(active) && view_s2.pd |-> kind == RD_SIG) else $error("read served in power-down");

    cov_enter_down: cover property (@(posedge clk_i) disable iff (reset_i)
        state == ST_ENTER ##1 state == ST_DOWN);
    cov_release: cover property (@(posedge clk_i) disable iff (reset_i)
        state == ST_RELEASE ##1 state == ST_STANDBY);
    cov_otp: cover property (@(posedge clk_i) disable iff (reset_i) $rose(otp_mode_o));
    cov_maker_swap: cover property (@(posedge sclk_i) disable iff (cs_n_i)
        active && swap);
endmodule
`default_nettype wire

// >>> tb/pdid_host.sv
// host controller model that frames commands on the serial link
`timescale 1ns/1ns
`default_nettype none
module pdid_host (
    // link pins
    output var  logic       sclk_o,
    output var  logic       cs_n_o,
    output var  logic [3:0] sio_o,
    output var  logic       quad_o,
    input  wire logic [3:0] dev_sio_i,
    input  wire logic [3:0] dev_oe_i
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sio_o  = 4'h0;
        quad_o = 1'b0;
    end

    // ====================================================
    // one frame; the clock stands still outside it
    task automatic frame(input logic [31:0] hdr, input int hbits, input logic q,
                         input int nrd, output logic [63:0] rd, output logic [3:0] oe);
        int step;
        step = q ? 4 : 1;
        rd = '0;
        oe = '0;
        quad_o = q;
        #3 cs_n_o = 1'b0;
        for (int i = 0; i < hbits; i += step)
        begin
            // upper lines toggle in serial mode, the device must not care
            sio_o = q ? hdr[31-i -: 4] : {~sio_o[3:1], hdr[31-i]};
            #6 sclk_o = 1'b1;
            #6 sclk_o = 1'b0;
        end
        for (int i = 0; i < nrd; i++)
        begin
            sio_o = ~sio_o;
            #6 rd = q ? {rd[59:0], dev_sio_i} : {rd[62:0], dev_sio_i[1]};
            oe = dev_oe_i;
            sclk_o = 1'b1;
            #6 sclk_o = 1'b0;
        end
        #3 cs_n_o = 1'b1;
        quad_o = 1'b0;
        sio_o = ~sio_o;
        #60;
    endtask
endmodule
`default_nettype wire

// >>> tb/test_pdid_cmd.sv
// self-checking bench for the power-down, id and otp command block
`timescale 1ns/1ns
`default_nettype none
module test_pdid_cmd;
    import pdid_pkg::*;
    // ====================================================
    // pins and bookkeeping
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        sclk, cs_n, quad, busy = 1'b0, pd, otp, wblock, ronly;
    logic [3:0]  sio_in, sio_out, sio_oe, oe;
    logic [9:0]  ev = '0;
    logic [2:0]  nv = '0;
    logic [63:0] rd;
    sec_flags_t  flags;
    int          error_cnt = 0;
    int          checked = 0;
    int          n;

    always #5 clk_i = ~clk_i;

    pdid_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .sio_o(sio_in), .quad_o(quad),
        .dev_sio_i(sio_out), .dev_oe_i(sio_oe));

    pdid_cmd i_dut (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .sio_i(sio_in), .sio_o(sio_out), .sio_oe_o(sio_oe), .quad_mode_i(quad),
        .busy_i(busy), .sw_reset_i(ev[0]), .erase_suspend_i(ev[1]), .erase_resume_i(ev[2]),
        .prog_suspend_i(ev[3]), .prog_resume_i(ev[4]), .erase_fail_i(ev[5]),
        .prog_fail_i(ev[6]), .fail_clear_i(ev[7]), .protect_method_select_set_i(ev[8]),
        .lockdown_req_i(ev[9]), .nv_protect_method_select_i(nv[0]), .nv_otp_lockdown_bit_i(nv[1]),
        .factory_lock_i(nv[2]), .power_down_o(pd), .otp_mode_o(otp),
        .reg_write_block_o(wblock), .otp_read_only_o(ronly), .security_flags_o(flags));

    // ====================================================
    // shared helpers
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic pulse(input int k);
        @(posedge clk_i) #1 ev[k] = 1'b1;
        @(posedge clk_i) #1 ev[k] = 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // bounded wait for a power-down level; cycles spent come back in n
    task automatic wait_pd(input logic lvl, input int lim);
        n = 0;
        while (pd !== lvl && n < lim)
            @(posedge clk_i) #1 n++;
        if (n >= lim)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: power-down level wait ran out", $time);
            report_and_stop();
        end
    endtask

    // ====================================================
    // scenarios
    task automatic s_flags;
        check({pd, otp, wblock, flags}, 0, "state after reset");
        pulse(1);
        pulse(3);
        // both fail flags in one cycle
        @(posedge clk_i) #1 ev[6:5] = 2'h3;
        @(posedge clk_i) #1 ev[6:5] = 2'h0;
        pulse(8);
        @(posedge clk_i) #1 nv[2] = 1'b1;
        i_host.frame({8'h2b, 24'h0}, 8, 1'b0, 16, rd, oe);
        check({oe, rd[15:0]}, {4'h2, 16'heded}, "flags read");
        @(posedge clk_i) #1 busy = 1'b1;
        pulse(2);
        pulse(7);
        pulse(9);
        i_host.frame({8'h2b, 24'h0}, 8, 1'b1, 2, rd, oe);
        check(rd[7:0], 8'h87, "flags after resume");
        pulse(0);
        // read during a write cycle, quad format; lock-down outlives software reset
        i_host.frame({8'h2b, 24'h0}, 8, 1'b1, 2, rd, oe);
        check(rd[7:0], 8'h83, "flags after clear");
        @(posedge clk_i) #1 busy = 1'b0;
    endtask

    task automatic s_ids;
        i_host.frame({8'hab, 24'h0}, 8, 1'b0, 16, rd, oe);
        check(rd[15:0], {2{i_dut.ID_PART}}, "signature");
        i_host.frame({8'h90, 24'h000001}, 32, 1'b0, 32, rd, oe);
        check(rd[31:0], {2{i_dut.ID_PART, i_dut.ID_MAKER}}, "swapped ids");
        i_host.frame({8'h90, 24'h000000}, 32, 1'b0, 32, rd, oe);
        check(rd[31:0], {2{i_dut.ID_MAKER, i_dut.ID_PART}}, "maker ids");
        i_host.frame({8'haf, 24'h0}, 8, 1'b1, 12, rd, oe);
        check({oe, rd[47:0]}, {4'hf, {2{i_dut.ID_MAKER, i_dut.ID_TYPE, i_dut.ID_PART}}},
            "quad ids");
    endtask

    task automatic s_otp;
        i_host.frame({8'hb1, 24'h0}, 8, 1'b1, 0, rd, oe);
        repeat (8) @(posedge clk_i);
        check({otp, wblock, ronly}, 3'h7, "otp entered");
        i_host.frame({8'hc1, 24'h0}, 8, 1'b0, 0, rd, oe);
        repeat (8) @(posedge clk_i);
        check({otp, wblock, ronly}, 3'h0, "otp left");
    endtask

    task automatic s_pd;
        i_host.frame({8'hb9, 24'h0}, 9, 1'b0, 0, rd, oe);
        repeat (1100) @(posedge clk_i);
        check(pd, 1'b0, "entry off boundary");
        i_host.frame({8'hb9, 24'h0}, 8, 1'b0, 0, rd, oe);
        wait_pd(1'b1, 1100);
        check({n >= 990, wblock}, 2'h3, "entry delay");
        i_host.frame({8'h2b, 24'h0}, 8, 1'b0, 8, rd, oe);
        check(oe, 4'h0, "flags read while down");
        i_host.frame({8'hab, 24'h0}, 8, 1'b1, 0, rd, oe);
        @(posedge clk_i) #1 busy = 1'b1;
        i_host.frame({8'hab, 24'h0}, 8, 1'b0, 0, rd, oe);
        repeat (1100) @(posedge clk_i);
        check(pd, 1'b1, "release refused");
        @(posedge clk_i) #1 busy = 1'b0;
        i_host.frame({8'hab, 24'h0}, 8, 1'b0, 8, rd, oe);
        check(rd[7:0], i_dut.ID_PART, "signature while down");
        wait_pd(1'b0, 1100);
        check(n >= 990, 1'b1, "release delay");
        i_host.frame({8'hb9, 24'h0}, 8, 1'b0, 0, rd, oe);
        wait_pd(1'b1, 1100);
        pulse(0);
        check(pd, 1'b0, "software reset ends power-down");
    endtask

    initial
    begin
        repeat (5) @(posedge clk_i);
        #1 reset_i = 1'b0;
        repeat (3) @(posedge clk_i);
        s_flags();
        s_ids();
        s_otp();
        s_pd();
        report_and_stop();
    end
endmodule
`default_nettype wire
